/* dv/pattern_sequencer_control_tb.sv */
`timescale 1ns/1ns
module pattern_sequencer_control_tb;
	import seq_pkg::*;
	logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, stall = 0;
	logic external_clock_input = 0, trigger_line_a = 0, trigger_line_b = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, word_data, word_oe, v;
	logic sync_out, stream_valid, stream_ready;
	logic [31:0] stream_data, first_word;
	int word_count, n, num_errors = 0, check_count = 0;

	always #5 ref_clk = ~ref_clk;

	pattern_sequencer_control #(.SYNC_LONG(20)) u_pattern_sequencer_control (.ref_clk, .rst,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .external_clock_input,
		.trigger_line_a, .trigger_line_b, .word_data, .word_oe, .sync_out, .stream_valid,
		.stream_ready, .stream_data);
	stream_sink u_stream_sink (.ref_clk, .rst, .stream_valid, .stream_data, .stall,
		.stream_ready, .word_count, .first_word);

	// ************************************************************
	// bus cycles and comparisons
	// ************************************************************
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim
	task automatic check16(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : check16
	task automatic check32(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: word %h expected %h", $time, g, e);
		end
	endtask : check32
	task automatic check_range(input int g, input int lo, input int hi);
		check_count++;
		if (g < lo || g > hi) begin
			num_errors++;
			$display("mismatch at %0t: count %0d outside %0d..%0d", $time, g, lo, hi);
		end
	endtask : check_range
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// read data is taken a full cycle after the strobe edge; it holds until the next read
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		#1 d = reg_rdata;
	endtask : rd
	task automatic wait_busy(input logic e);
		logic [15:0] s;
		for (int i = 0; i < 60; i++) begin
			rd(OFF_CONTROL, s);
			if (s[CS_BUSY] === e)
				return;
		end
		num_errors++;
		$display("mismatch at %0t: busy wait ran out", $time);
		end_sim();
	endtask : wait_busy
	// cycles until word_data moves; 99 means it never did
	task automatic count_change(output int c);
		logic [15:0] w;
		w = word_data;
		for (c = 1; c <= 40; c++) begin
			@(posedge ref_clk);
			#1 if (word_data !== w)
				return;
		end
		c = 99;
	endtask : count_change
	task automatic pin(input logic [1:0] src, input logic lvl);
		@(posedge ref_clk);
		case (src)
			CLK_SRC_EXTERNAL: external_clock_input <= lvl;
			CLK_SRC_TRIG_A: trigger_line_a <= lvl;
			default: trigger_line_b <= lvl;
		endcase
	endtask : pin

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic regs_and_memory();
		rd(OFF_CONTROL, v); check16(v, 16'h0000);
		rd(OFF_LOOP, v); check16(v, 16'h0001);
		wr(8'h10, 16'hbeef);
		rd(8'h10, v); check16(v, 16'h0000);
		wr(OFF_USER_ADDR, 16'h0000);
		wr(OFF_USER_DATA, 16'h0000);
		wr(OFF_USER_DATA, 16'h1111);
		wr(OFF_USER_DATA, 16'h00ff);
		wr(OFF_USER_DATA, 16'ha5c3);
		wr(OFF_USER_ADDR, 16'h0001);
		rd(OFF_USER_DATA, v); check16(v, 16'h1111);
		rd(OFF_USER_DATA, v); check16(v, 16'h00ff);
		wr(OFF_OUT_CFG, 16'h0100);
		rd(OFF_USER_DATA, v); check16(v, 16'ha5c3);
		rd(OFF_USER_DATA, v); check16(v, 16'ha5c3);
		rd(OFF_USER_ADDR, v); check16(v, 16'h0003);
		wr(OFF_OUT_CFG, 16'h0000);
	endtask : regs_and_memory
	task automatic single_run();
		wr(OFF_START, 16'h0001);
		wr(OFF_END, 16'h0001);
		wr(OFF_USER_ADDR, 16'h0000);
		repeat (3) @(posedge ref_clk);
		#1 check16(word_data, 16'h1111);
		wr(OFF_CONTROL, 16'h0020);
		// a one-word run parks at the next edge, so look in the load cycle itself
		#1 check16(word_data, 16'ha5c3);
		check16(word_oe, 16'hff00);
		check16({15'h0, sync_out}, 16'h0001);
		wait_busy(1'b0);
		check16(word_data, 16'h1111);
		check32(first_word, 32'hff00a5c3);
		check_range(word_count, 1, 1);
	endtask : single_run
	// continuous run alternating words 0 and 1; sync follows word 1, then a long stall
	task automatic continuous_run();
		wr(OFF_START, 16'h0000);
		wr(OFF_LOOP, 16'h0000);
		wr(OFF_SYNC_ADDR, 16'h0001);
		wr(OFF_CONTROL, 16'h0060);
		n = 0;
		repeat (40) begin
			@(posedge ref_clk);
			#1 n += sync_out;
		end
		check_range(n, 5, 35);
		stall <= 1'b1;
		n = 0;
		repeat (30) begin
			@(posedge ref_clk);
			#1 n += stream_valid;
		end
		check_range(n, 30, 30);
		stall <= 1'b0;
		rd(OFF_CONTROL, v); check16({15'h0, v[CS_BUSY]}, 16'h0001);
		wr(OFF_CONTROL, 16'h0000);
		wait_busy(1'b0);
		wr(OFF_LOOP, 16'h0001);
	endtask : continuous_run
	// external source starts on its falling edge, triggers on their rising edge
	task automatic pin_start(input logic [1:0] src);
		logic fall;
		fall = (src == CLK_SRC_EXTERNAL);
		wr(OFF_START, 16'h0001);
		wr(OFF_LOOP, 16'h0000);
		wr(OFF_CONTROL, {13'h0, fall, src});
		pin(src, fall);
		repeat (12) @(posedge ref_clk);
		#1 check16(word_data, 16'h1111);
		pin(src, !fall);
		count_change(n);
		check_range(n, EXT_SKEW_MIN_CYCLES, EXT_SKEW_MAX_CYCLES);
		pin(src, 1'b0);
		wr(OFF_CONTROL, 16'h0000);
		wait_busy(1'b0);
		wr(OFF_LOOP, 16'h0001);
	endtask : pin_start
	// timing mode with the external source selected still runs on the internal base
	task automatic timing_run();
		wr(OFF_USER_ADDR, 16'h0002);
		wr(OFF_USER_DATA, 16'h0003);
		wr(OFF_USER_ADDR, 16'h0000);
		wr(OFF_CONTROL, 16'h0031);
		count_change(n);
		check_range(n, 1, 1);
		count_change(n);
		check_range(n, 6, 16);
		check16(word_data, 16'h1111);
		wait_busy(1'b0);
	endtask : timing_run

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		regs_and_memory();
		single_run();
		continuous_run();
		for (int s = 1; s < 4; s++)
			pin_start(s[1:0]);
		timing_run();
		end_sim();
	end
endmodule : pattern_sequencer_control_tb

/* dv/stream_sink.sv */
`timescale 1ns/1ns
// ************************************************************
// receiver of the output-word stream
// ************************************************************
module stream_sink (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic stream_valid,
	input wire logic [31:0] stream_data,
	input wire logic stall,
	output logic stream_ready,
	output int word_count,
	output logic [31:0] first_word
);
	// a stalled receiver refuses every word, so the buffer must hold them
	assign stream_ready = !stall;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			word_count <= 0;
			first_word <= 32'h0;
		end else if (stream_valid && stream_ready) begin
			if (word_count == 0)
				first_word <= stream_data;
			word_count <= word_count + 1;
		end
	end
endmodule : stream_sink

/* verilog/pattern_sequencer_control.sv */
// Operation
// [R1] memory is addressed as 16-bit words; sequencing uses pairs as 32-bit words
// [R2] host writes user address then accesses user data; address then increments
// [R3] pointers index 32-bit words; control half at 2p, data half at 2p+1
// [R4] even half: tristate (word mode) or time (timing mode); odd half: data
// [R5] word mode clock: internal, external or either trigger, chosen edge
// [R6] timing mode always uses the internal 40MHz time base
// [R7] cycle select 0 gives single cycle; repetitions come from loop count
// [R8] single cycle idles at user address until software, external or trigger run
// [R9] after the end word, return to user address and halt per loop count
// [R10] while idle outputs hold the user address data
// [R11] timing mode external clock restarts a cycle after each completes
// [R12] word mode loads first word, shifts, and reloads user data at end
// [R13] external start edge is synchronised, skew between 50ns and 175ns
// [R14] sync on each word: pulse on load and shift, timing mode load only
// [R15] sync pulse width selectable: 50ns, 900ns or 800us
// [R16] sync on address: asserted while address counter equals sync address
// [R17] loop count zero makes the unit run continuously
// [R18] increment inhibit bit suppresses the user address increment
// [R19] continuous mode wraps from end to start until software stops it
`timescale 1ns/1ns
module pattern_sequencer_control
	import seq_pkg::*;
#(
	parameter int ADDR_W = 16,
	parameter int SYNC_LONG = SYNC_LONG_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic external_clock_input,
	input wire logic trigger_line_a,
	input wire logic trigger_line_b,
	output logic [15:0] word_data,
	output logic [15:0] word_oe,
	output logic sync_out,
	output logic stream_valid,
	input wire logic stream_ready,
	output logic [31:0] stream_data
);
	import seq_pkg::*;

	initial begin
		if (ADDR_W < 2 || ADDR_W > 16) $error("ADDR_W must be 2..16");
		if (SYNC_LONG < 1 || SYNC_LONG > 131071) $error("SYNC_LONG out of range");
		if (EXT_DELAY_STAGES < 1) $error("external delay line needs a stage");
	end

	// ************************************************************
	// registers and memory
	// ************************************************************
	logic [15:0] mem [0:(1<<ADDR_W)-1];
	logic [15:0] control;
	logic [15:0] int_div;
	logic [15:0] start_pointer;
	logic [15:0] end_pointer;
	logic [15:0] output_configuration;
	logic [15:0] sync_pointer;
	logic [15:0] memory_access_address;
	logic [15:0] loop_count;
	seq_state_t state;
	logic data_access;
	logic [ADDR_W-1:0] user_phys;
	logic sw_start;

	assign user_phys = memory_access_address[ADDR_W-1:0];
	assign data_access = (reg_wr || reg_rd) && reg_addr == OFF_USER_DATA;
	assign sw_start = reg_wr && reg_addr == OFF_CONTROL && reg_wdata[CS_RUN];

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			control <= CONTROL_RESET;
			int_div <= INT_DIV_RESET;
			start_pointer <= 16'h0000;
			end_pointer <= 16'h0000;
			output_configuration <= OUT_CFG_RESET;
			sync_pointer <= 16'h0000;
			loop_count <= LOOP_RESET;
		end else if (reg_wr) begin
			case (reg_addr)
				OFF_CONTROL: control <= reg_wdata;
				OFF_INT_DIV: int_div <= reg_wdata;
				OFF_START: start_pointer <= reg_wdata;
				OFF_END: end_pointer <= reg_wdata;
				OFF_OUT_CFG: output_configuration <= reg_wdata;
				OFF_SYNC_ADDR: sync_pointer <= reg_wdata;
				OFF_LOOP: loop_count <= reg_wdata; // see [R7]
				default: ;
			endcase
		end
	end

	// user address auto-increments after each data access unless the increment inhibit bit is set
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			memory_access_address <= 16'h0000;
		end else if (reg_wr && reg_addr == OFF_USER_ADDR) begin
			memory_access_address <= reg_wdata;
		end else if (data_access && !output_configuration[OC_INC_INHIBIT]) begin // see [R18]
			memory_access_address <= memory_access_address + 16'h0001; // see [R2]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reg_wr && reg_addr == OFF_USER_DATA) begin
			mem[user_phys] <= reg_wdata; // see [R1]
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				OFF_CONTROL: reg_rdata <= {state == st_run, control[14:0]};
				OFF_INT_DIV: reg_rdata <= int_div;
				OFF_START: reg_rdata <= start_pointer;
				OFF_END: reg_rdata <= end_pointer;
				OFF_OUT_CFG: reg_rdata <= output_configuration;
				OFF_SYNC_ADDR: reg_rdata <= sync_pointer;
				OFF_USER_ADDR: reg_rdata <= memory_access_address;
				OFF_USER_DATA: reg_rdata <= mem[user_phys];
				OFF_LOOP: reg_rdata <= loop_count;
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end

	// ************************************************************
	// clock sources
	// ************************************************************
	logic timing_mode;
	logic continuous;
	logic [1:0] src_sel;
	logic src_raw;
	logic src_meta;
	logic src_sync;
	logic src_prev;
	logic src_edge;
	logic [EXT_DELAY_STAGES-1:0] edge_dly;
	logic [15:0] div_cnt;
	logic int_tick;
	logic [6:0] base_acc;
	logic base_tick;
	logic src_event;

	assign timing_mode = control[CS_TIMING_MODE];
	assign continuous = control[CS_CYCLE] || loop_count == 16'h0000; // see [R7] [R17]
	assign src_sel = control[CS_CLK_SRC_LSB +: 2];

	always_comb begin
		case (src_sel) // see [R5]
			CLK_SRC_EXTERNAL: src_raw = external_clock_input;
			CLK_SRC_TRIG_A: src_raw = trigger_line_a;
			CLK_SRC_TRIG_B: src_raw = trigger_line_b;
			default: src_raw = 1'b0;
		endcase
	end

	// the delay line tops up synchroniser latency to the least skew
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			src_meta <= 1'b0;
			src_sync <= 1'b0;
			src_prev <= 1'b0;
			edge_dly <= '0;
		end else begin
			src_meta <= src_raw;
			src_sync <= src_meta;
			src_prev <= src_sync;
			edge_dly <= EXT_DELAY_STAGES'({edge_dly, src_edge}); // see [R13]
		end
	end
	assign src_edge = control[CS_CLK_FALL] ? (src_prev && !src_sync) : (!src_prev && src_sync);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_cnt <= 16'h0000;
		end else begin
			div_cnt <= int_tick ? 16'h0000 : div_cnt + 16'h0001;
		end
	end
	assign int_tick = div_cnt >= int_div;

	// phase accumulator: 40 of every 100 reference edges, jitter of one cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			base_acc <= 7'h00;
		end else begin
			base_acc <= base_tick ? base_acc + 7'(TIMING_BASE_MHZ - REF_MHZ)
				: base_acc + 7'(TIMING_BASE_MHZ);
		end
	end
	assign base_tick = (base_acc + 7'(TIMING_BASE_MHZ)) >= 7'(REF_MHZ); // see [R6]
	assign src_event = (src_sel == CLK_SRC_INTERNAL) ? int_tick : edge_dly[EXT_DELAY_STAGES-1];

	// ************************************************************
	// sequencer
	// ************************************************************
	logic [15:0] ptr;
	logic [15:0] shreg;
	logic [15:0] tris;
	logic [4:0] remain;
	logic [15:0] time_left;
	logic [15:0] loops_done;
	logic [3:0] size_code;
	logic [4:0] shift_bits;
	logic [4:0] per_word;
	logic buf_ready;
	logic advance;
	logic start_req;
	logic do_load;
	logic do_shift;
	logic do_park;
	logic [15:0] next_ptr;
	logic [15:0] next_shreg;
	logic [15:0] next_tris;
	logic [15:0] fetch_ctrl;
	logic [15:0] fetch_data;
	logic [ADDR_W-1:0] fetch_phys;
	logic [ADDR_W-1:0] idle_phys;

	assign size_code = output_configuration[OC_SIZE_LSB +: 4];
	always_comb begin
		if (size_code == 4'h1) shift_bits = 5'd1;
		else if (size_code == 4'h2) shift_bits = 5'd2;
		else if (size_code == 4'h3 || size_code == 4'h4) shift_bits = 5'd4;
		else if (size_code >= 4'h5 && size_code <= 4'h8) shift_bits = 5'd8;
		else shift_bits = 5'd16;
		per_word = 5'(16 / shift_bits);
	end

	assign start_req = sw_start || (src_sel != CLK_SRC_INTERNAL && src_event); // see [R8] [R11]
	assign advance = timing_mode ? (base_tick && time_left == 16'h0000) : src_event; // see [R6]
	assign fetch_phys = ADDR_W'({next_ptr, 1'b0}); // see [R3]
	assign fetch_ctrl = mem[fetch_phys];
	assign fetch_data = mem[fetch_phys | ADDR_W'(1)]; // see [R1]
	// idle level: the 32-bit word that holds the user address
	assign idle_phys = user_phys & ~ADDR_W'(1);

	always_comb begin
		do_load = 1'b0;
		do_shift = 1'b0;
		do_park = 1'b0;
		next_ptr = ptr;
		case (state)
			st_idle: begin
				if (start_req && buf_ready) begin
					do_load = 1'b1;
					next_ptr = start_pointer;
				end
			end
			st_run: begin
				// clearing run stops any endless run, whether set by cycle bit or loop count
				if (continuous && !control[CS_RUN]) begin
					do_park = 1'b1; // see [R19]
				end else if (advance && buf_ready) begin
					if (!timing_mode && remain > 5'd1) begin
						do_shift = 1'b1;
					end else if (ptr != end_pointer) begin
						do_load = 1'b1;
						next_ptr = ptr + 16'h0001;
					end else if (continuous || loops_done + 16'h0001 < loop_count) begin
						do_load = 1'b1; // see [R19] [R17]
						next_ptr = start_pointer;
					end else begin
						do_park = 1'b1; // see [R9]
					end
				end
			end
			default: do_park = 1'b1;
		endcase
		// even half is tristate in word mode, time in timing mode
		if (do_load) begin
			next_shreg = fetch_data; // see [R4]
			next_tris = timing_mode ? 16'h0000 : fetch_ctrl;
		end else if (do_shift) begin
			next_shreg = shreg >> shift_bits; // see [R12]
			next_tris = tris;
		end else if (state == st_idle || do_park) begin
			next_shreg = mem[idle_phys | ADDR_W'(1)]; // see [R10] [R12]
			next_tris = timing_mode ? 16'h0000 : mem[idle_phys];
		end else begin
			next_shreg = shreg;
			next_tris = tris;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= st_idle;
			ptr <= 16'h0000;
			remain <= 5'd0;
			time_left <= 16'h0000;
			loops_done <= 16'h0000;
		end else begin
			ptr <= next_ptr;
			if (do_park) begin
				state <= st_idle;
			end else if (do_load) begin
				state <= st_run;
				remain <= (next_ptr == end_pointer
					&& output_configuration[OC_LAST_COUNT_LSB +: 4] != 4'h0)
					? {1'b0, output_configuration[OC_LAST_COUNT_LSB +: 4]} : per_word;
				time_left <= fetch_ctrl; // see [R4]
				if (state == st_idle) loops_done <= 16'h0000;
				else if (ptr == end_pointer) loops_done <= loops_done + 16'h0001;
			end else if (do_shift) begin
				remain <= remain - 5'd1;
			end else if (state == st_run && timing_mode && base_tick && time_left != 16'h0000) begin
				time_left <= time_left - 16'h0001;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			shreg <= 16'h0000;
			tris <= 16'hffff;
			word_data <= 16'h0000;
			word_oe <= 16'h0000;
		end else begin
			shreg <= next_shreg;
			tris <= next_tris;
			word_data <= next_shreg;
			word_oe <= ~next_tris;
		end
	end

	// a stall by the receiver holds the sequencer, so no word is dropped
	two_entry_buffer #(.WIDTH(32)) out_buf (
		.ref_clk(ref_clk),
		.rst(rst),
		.in_valid(do_load || do_shift),
		.in_ready(buf_ready),
		.in_data({~next_tris, next_shreg}),
		.out_valid(stream_valid),
		.out_ready(stream_ready),
		.out_data(stream_data)
	);

	// ************************************************************
	// sync output
	// ************************************************************
	logic [16:0] sync_cnt;
	logic sync_evt;
	logic [1:0] sync_w;

	assign sync_w = control[CS_SYNC_WIDTH_LSB +: 2];
	assign sync_evt = do_load || (do_shift && !timing_mode); // see [R14]

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync_cnt <= 17'h00000;
		end else if (sync_evt) begin
			sync_cnt <= (sync_w == SYNC_W_SHORT) ? 17'(SYNC_SHORT_CYCLES) // see [R15]
				: (sync_w == SYNC_W_MID) ? 17'(SYNC_MID_CYCLES) : 17'(SYNC_LONG);
		end else if (sync_cnt != 17'h00000) begin
			sync_cnt <= sync_cnt - 17'h00001;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync_out <= 1'b0;
		end else if (control[CS_SYNC_ADDR_MODE]) begin
			sync_out <= (next_ptr == sync_pointer) && (do_load || (state == st_run && !do_park)); // see [R16]
		end else begin
			sync_out <= (sync_evt || sync_cnt > 17'h00001);
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_user_incr: assert property ((data_access && !(reg_wr && reg_addr == OFF_USER_ADDR) && !output_configuration[OC_INC_INHIBIT]) |=> memory_access_address == $past(memory_access_address) + 16'h0001) else $error("user address did not increment"); // see [R2]
	a_incr_inhibit: assert property ((data_access && output_configuration[OC_INC_INHIBIT] && !reg_wr) |=> $stable(memory_access_address)) else $error("user address moved while inhibited"); // see [R18]
	a_load_data: assert property (do_load |=> shreg == $past(fetch_data) && word_data == shreg) else $error("loaded word is not the pointer data half"); // see [R3]
	a_idle_hold: assert property ((state == st_idle && !do_load) |=> // see [R10]
		word_data === mem[idle_phys | ADDR_W'(1)] || $changed(memory_access_address))
		else $error("idle output not user data");
	a_park_halt: assert property ((state == st_run && do_park) |=> state == st_idle ##1 (state == st_idle || $past(start_req))) else $error("sequencer did not halt after last loop"); // see [R9]
	a_wrap_cont: assert property ((state == st_run && advance && buf_ready // see [R19]
		&& ptr == end_pointer && (remain <= 5'd1 || timing_mode) && continuous
		&& control[CS_RUN]) |=> state == st_run && ptr == $past(start_pointer))
		else $error("continuous run did not wrap");
	a_short_sync: assert property ((sync_evt && !control[CS_SYNC_ADDR_MODE] && sync_w == SYNC_W_SHORT) |=> sync_out [*5]) else $error("short sync pulse too short"); // see [R15]
	a_base_rate: assert property (base_tick |=> !base_tick) // see [R6]
		else $error("time base above 40MHz");
	a_ext_skew: assert property ((src_edge && src_sel != CLK_SRC_INTERNAL) |-> ##2 src_event) else $error("external edge not delayed to least skew"); // see [R13]
	a_addr_sync: assert property ((control[CS_SYNC_ADDR_MODE] && state == st_run && !do_park && next_ptr == sync_pointer) |=> sync_out) else $error("address sync missing"); // see [R16]

	c_single_done: cover property (state == st_run && do_park && !continuous);
	c_wrap: cover property (state == st_run && do_load && next_ptr == start_pointer);
	c_stall: cover property (stream_valid && !stream_ready && !buf_ready);
	c_ext_start: cover property (state == st_idle && do_load && src_sel == CLK_SRC_EXTERNAL);
endmodule : pattern_sequencer_control

/* verilog/seq_pkg.sv */
package seq_pkg;
	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_INT_DIV = 8'h04;
	localparam logic [7:0] OFF_START = 8'h06;
	localparam logic [7:0] OFF_END = 8'h08;
	localparam logic [7:0] OFF_OUT_CFG = 8'h0c;
	localparam logic [7:0] OFF_SYNC_ADDR = 8'h0e;
	localparam logic [7:0] OFF_USER_ADDR = 8'h18;
	localparam logic [7:0] OFF_USER_DATA = 8'h1a;
	localparam logic [7:0] OFF_LOOP = 8'h1c;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CS_CLK_SRC_LSB = 0;
	localparam int CS_CLK_FALL = 2;
	localparam int CS_CYCLE = 3;
	localparam int CS_TIMING_MODE = 4;
	localparam int CS_RUN = 5;
	localparam int CS_SYNC_ADDR_MODE = 6;
	localparam int CS_SYNC_WIDTH_LSB = 7;
	localparam int CS_BUSY = 15;
	localparam int OC_SIZE_LSB = 0;
	localparam int OC_LAST_COUNT_LSB = 4;
	localparam int OC_INC_INHIBIT = 8;

	localparam logic [1:0] CLK_SRC_INTERNAL = 2'h0;
	localparam logic [1:0] CLK_SRC_EXTERNAL = 2'h1;
	localparam logic [1:0] CLK_SRC_TRIG_A = 2'h2;
	localparam logic [1:0] CLK_SRC_TRIG_B = 2'h3;
	localparam logic [1:0] SYNC_W_SHORT = 2'h0;
	localparam logic [1:0] SYNC_W_MID = 2'h1;

	// ************************************************************
	// values after reset
	// ************************************************************
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] OUT_CFG_RESET = 16'h0000;
	localparam logic [15:0] LOOP_RESET = 16'h0001;
	localparam logic [15:0] INT_DIV_RESET = 16'h0000;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int REF_MHZ = 100;
	localparam int TIMING_BASE_MHZ = 40;
	localparam int SYNC_SHORT_NS = 50;
	localparam int SYNC_MID_NS = 900;
	localparam int SYNC_LONG_US = 800;
	localparam int SYNC_SHORT_CYCLES = (SYNC_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_MID_CYCLES = (SYNC_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_LONG_CYCLES = (SYNC_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXT_SKEW_MIN_NS = 50;
	localparam int EXT_SKEW_MAX_NS = 175;
	localparam int EXT_SKEW_MIN_CYCLES = (EXT_SKEW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXT_SKEW_MAX_CYCLES = EXT_SKEW_MAX_NS / CLK_PERIOD_NS;
	// two synchroniser flops before the delay line and the load flop after it take three cycles; the edge is combinational
	localparam int EXT_DELAY_STAGES = EXT_SKEW_MIN_CYCLES - 3;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_run = 2'b01
	} seq_state_t;
endpackage : seq_pkg

/* verilog/two_entry_buffer.sv */
`timescale 1ns/1ns
module two_entry_buffer #(
	parameter int WIDTH = 32
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] head;
	logic [WIDTH-1:0] tail;
	logic [1:0] count;
	logic push;
	logic pop;

	initial begin
		if (WIDTH < 1) $error("two_entry_buffer: WIDTH must be at least 1");
	end

	assign in_ready = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data = head;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count <= 2'h0;
		end else begin
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			head <= '0;
			tail <= '0;
		end else begin
			if (count == 2'h0 || (count == 2'h1 && pop)) begin
				if (push) head <= in_data;
			end else if (pop) begin
				head <= tail;
			end
			if (push && ((count == 2'h1 && !pop) || (count == 2'h2))) begin
				tail <= in_data;
			end
		end
	end
endmodule : two_entry_buffer
